// [src/tlfs_params.svh]
/*
  offsets, field positions, reset values and the clock period for the
  travel limit and fault status block.
  assumes inclusion by bare name from the block's design files.
*/
`ifndef TLFS_PARAMS_SVH
`define TLFS_PARAMS_SVH

// clock
`define TLFS_CLK_PERIOD_NS 10

// register byte offsets on the bus
`define TLFS_ADDR_W 8
`define TLFS_OFS_STATUS 8'h00
`define TLFS_OFS_COMMAND 8'h04
`define TLFS_OFS_IO_STATE 8'h08

// command register fields
`define TLFS_CMD_OP_LSB 0
`define TLFS_CMD_OP_MSB 1
`define TLFS_CMD_IDX_LSB 4
`define TLFS_CMD_IDX_MSB 6
`define TLFS_CMD_WORD_LSB 8
`define TLFS_CMD_WORD_MSB 11
`define TLFS_LOCAL_WORD 4'h0

// io state register fields
`define TLFS_IOS_LEVEL_LSB 0
`define TLFS_IOS_MASK_LSB 8

// local io
`define TLFS_IO_COUNT 7
`define TLFS_IO_POS_LIMIT 2
`define TLFS_IO_NEG_LIMIT 3
`define TLFS_IO_LEVEL_RESET 7'h7f
`define TLFS_GEN_MASK_RESET 7'h73
`define TLFS_GEN_MASK_ALL 7'h7f

// status word bit positions
`define TLFS_ST_DRIVE_READY 0
`define TLFS_ST_MOTOR_OFF 1
`define TLFS_ST_BUS_VOLT 3
`define TLFS_ST_OVERCURRENT 4
`define TLFS_ST_OVERTEMP 5
`define TLFS_ST_POS_ERROR 6
`define TLFS_ST_RT_TEMP_LIMIT 8
`define TLFS_ST_DERR_LIMIT 9
`define TLFS_ST_POS_EN 10
`define TLFS_ST_NEG_EN 11
`define TLFS_ST_POS_HIST 12
`define TLFS_ST_NEG_HIST 13
`define TLFS_ST_POS_ASSERT 14
`define TLFS_ST_NEG_ASSERT 15
`define TLFS_STATUS_RESET 16'h0000

// sticky flag vector layout
`define TLFS_STICKY_COUNT 6
`define TLFS_SK_POS_HIST 0
`define TLFS_SK_NEG_HIST 1
`define TLFS_SK_BUS_VOLT 2
`define TLFS_SK_OVERCURRENT 3
`define TLFS_SK_OVERTEMP 4
`define TLFS_SK_POS_ERROR 5
`define TLFS_STICKY_RESET 6'h00

`endif

// [src/tlfs_pin_sync.sv]
/*
  three-stage synchroniser with agreement filter for the local io pins.
  assumes pins are asynchronous to ref_clk_in; a change is taken once
  the second and third stages agree.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tlfs_params.svh"

module tlfs_pin_sync (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [`TLFS_IO_COUNT-1:0] pin_in,
  output logic [`TLFS_IO_COUNT-1:0] level_out
);
  import tlfs_pkg::*;

  localparam logic [`TLFS_IO_COUNT-1:0] LEVEL_RESET = `TLFS_IO_LEVEL_RESET;

  genvar gi;
  generate
    for (gi = 0; gi < `TLFS_IO_COUNT; gi = gi + 1) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic next_lvl;

      always_comb begin
        next_lvl = lvl;
        if (s2 == s3) begin
          next_lvl = s3;
        end
      end

      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          s1 <= LEVEL_RESET[gi];
          s2 <= LEVEL_RESET[gi];
          s3 <= LEVEL_RESET[gi];
          lvl <= LEVEL_RESET[gi];
        end else begin
          s1 <= pin_in[gi];
          s2 <= s1;
          s3 <= s2;
          lvl <= next_lvl;
        end
      end

      assign level_out[gi] = lvl;
    end
  endgenerate

endmodule // tlfs_pin_sync
`default_nettype wire

// [src/tlfs_pkg.sv]
/*
  types for the travel limit and fault status block.
  assumes tlfs_params.svh is on the include path.
*/
`include "tlfs_params.svh"

package tlfs_pkg;

  typedef logic [15:0] tlfs_status_t;

  typedef enum logic [1:0] {
    TLFS_BUS_IDLE = 2'h0,
    TLFS_BUS_ACK = 2'h1
  } tlfs_bus_state_t;

  typedef enum logic [1:0] {
    TLFS_CMD_NONE = 2'h0,
    TLFS_CMD_IO_BIT = 2'h1,
    TLFS_CMD_IO_WORD = 2'h2,
    TLFS_CMD_CLEAR_FLAGS = 2'h3
  } tlfs_cmd_t;

endpackage

// [src/tlfs_sticky_bits.sv]
/*
  sticky flag bank: each bit sets on its event and holds until cleared.
  assumes set and clear are on ref_clk_in; a set in the clear cycle wins.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tlfs_params.svh"

module tlfs_sticky_bits (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [`TLFS_STICKY_COUNT-1:0] set_in,
  input wire logic clear_in,
  output logic [`TLFS_STICKY_COUNT-1:0] flag_out
);
  import tlfs_pkg::*;

  localparam logic [`TLFS_STICKY_COUNT-1:0] FLAG_RESET = `TLFS_STICKY_RESET;

  genvar gi;
  generate
    for (gi = 0; gi < `TLFS_STICKY_COUNT; gi = gi + 1) begin : g_bit
      logic flag;
      logic next_flag;

      always_comb begin
        next_flag = (flag & ~clear_in) | set_in[gi];
      end

      always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          flag <= FLAG_RESET[gi];
        end else begin
          flag <= next_flag;
        end
      end

      assign flag_out[gi] = flag;
    end
  endgenerate

endmodule // tlfs_sticky_bits
`default_nettype wire

// [src/tlfs_top.sv]
/*
  travel limit and fault status block: status word, limit release and
  flag clear commands, reached over a classic wishbone slave.
  assumes fault inputs come from drive logic on ref_clk_in and local io
  pins are asynchronous; an open limit pin reads high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tlfs_params.svh"

module tlfs_top (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [`TLFS_ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [`TLFS_IO_COUNT-1:0] io_pin_in,
  input wire logic drive_ready_in,
  input wire logic motor_off_flag_in,
  input wire logic bus_voltage_fault_in,
  input wire logic overcurrent_in,
  input wire logic overtemperature_flag_in,
  input wire logic position_error_flag_in,
  input wire logic rt_temp_limit_in,
  input wire logic derr_limit_in,
  output logic [`TLFS_IO_COUNT-1:0] general_use_mask_out,
  output logic pos_limit_asserted_flag_out,
  output logic neg_limit_asserted_flag_out,
  output tlfs_pkg::tlfs_status_t status_word_out
);
  import tlfs_pkg::*;

  localparam logic [`TLFS_IO_COUNT-1:0] GEN_MASK_RESET = `TLFS_GEN_MASK_RESET;
  localparam logic [`TLFS_IO_COUNT-1:0] GEN_MASK_ALL = `TLFS_GEN_MASK_ALL;
  localparam logic [2:0] IO_IDX_LAST = 3'h6;

  // bus slave state
  tlfs_bus_state_t state;
  tlfs_bus_state_t next_state;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // command decode
  logic cmd_write;
  tlfs_cmd_t cmd_op;
  logic [2:0] cmd_idx;
  logic [3:0] cmd_word;
  logic clear_flags;

  // io and limit state
  logic [`TLFS_IO_COUNT-1:0] io_level;
  logic [`TLFS_IO_COUNT-1:0] gen_mask;
  logic [`TLFS_IO_COUNT-1:0] next_gen_mask;
  logic pos_en;
  logic neg_en;
  logic pos_assert;
  logic neg_assert;

  // sticky flags and status
  logic [`TLFS_STICKY_COUNT-1:0] sticky_set;
  logic [`TLFS_STICKY_COUNT-1:0] sticky;
  tlfs_status_t status;
  tlfs_status_t next_status;

  tlfs_pin_sync u_pin_sync (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .pin_in(io_pin_in),
    .level_out(io_level)
  );

  // bus slave: ack one cycle after the request is seen
  always_comb begin
    next_state = state;
    next_ack = 1'b0;
    next_rdata = rdata;
    case (state)
      TLFS_BUS_IDLE: begin
        if (wb_cyc_in && wb_stb_in) begin
          next_state = TLFS_BUS_ACK;
          next_ack = 1'b1;
          next_rdata = 32'h0000_0000;
          if (!wb_we_in) begin
            case (wb_adr_in)
              `TLFS_OFS_STATUS: begin
                next_rdata = {16'h0000, status};
              end
              `TLFS_OFS_IO_STATE: begin
                next_rdata[`TLFS_IOS_LEVEL_LSB +: `TLFS_IO_COUNT] = io_level;
                next_rdata[`TLFS_IOS_MASK_LSB +: `TLFS_IO_COUNT] = gen_mask;
              end
              default: begin
                next_rdata = 32'h0000_0000;
              end
            endcase
          end
        end
      end
      TLFS_BUS_ACK: begin
        next_state = TLFS_BUS_IDLE;
        next_ack = 1'b0;
      end
      default: begin
        next_state = TLFS_BUS_IDLE;
        next_ack = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= TLFS_BUS_IDLE;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_out = ack;
  assign wb_dat_out = rdata;

  // command acts at the edge where the master samples ack
  always_comb begin
    cmd_write = (state == TLFS_BUS_ACK) && wb_cyc_in && wb_stb_in && wb_we_in
      && (wb_adr_in == `TLFS_OFS_COMMAND) && wb_sel_in[0];
    cmd_op = tlfs_cmd_t'(wb_dat_in[`TLFS_CMD_OP_MSB:`TLFS_CMD_OP_LSB]);
    cmd_idx = wb_dat_in[`TLFS_CMD_IDX_MSB:`TLFS_CMD_IDX_LSB];
    cmd_word = `TLFS_LOCAL_WORD;
    if (wb_sel_in[1]) begin
      cmd_word = wb_dat_in[`TLFS_CMD_WORD_MSB:`TLFS_CMD_WORD_LSB];
    end
    clear_flags = cmd_write && (cmd_op == TLFS_CMD_CLEAR_FLAGS);
  end

  // general-use mask; a released io stays released until reset
  always_comb begin
    next_gen_mask = gen_mask;
    if (cmd_write && (cmd_op == TLFS_CMD_IO_BIT) && (cmd_idx <= IO_IDX_LAST)) begin
      next_gen_mask[cmd_idx] = 1'b1;
    end
    if (cmd_write && (cmd_op == TLFS_CMD_IO_WORD) && (cmd_word == `TLFS_LOCAL_WORD)) begin
      next_gen_mask = GEN_MASK_ALL;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gen_mask <= GEN_MASK_RESET;
    end else begin
      gen_mask <= next_gen_mask;
    end
  end

  assign general_use_mask_out = gen_mask;

  // limit function and its live state
  always_comb begin
    pos_en = ~gen_mask[`TLFS_IO_POS_LIMIT];
    neg_en = ~gen_mask[`TLFS_IO_NEG_LIMIT];
    pos_assert = pos_en & io_level[`TLFS_IO_POS_LIMIT];
    neg_assert = neg_en & io_level[`TLFS_IO_NEG_LIMIT];
  end

  // latched records of limits and drive faults
  always_comb begin
    sticky_set = '0;
    sticky_set[`TLFS_SK_POS_HIST] = pos_assert;
    sticky_set[`TLFS_SK_NEG_HIST] = neg_assert;
    sticky_set[`TLFS_SK_BUS_VOLT] = bus_voltage_fault_in;
    sticky_set[`TLFS_SK_OVERCURRENT] = overcurrent_in;
    sticky_set[`TLFS_SK_OVERTEMP] = overtemperature_flag_in;
    sticky_set[`TLFS_SK_POS_ERROR] = position_error_flag_in;
  end

  tlfs_sticky_bits u_sticky (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .set_in(sticky_set),
    .clear_in(clear_flags),
    .flag_out(sticky)
  );

  // status word assembly
  always_comb begin
    next_status = `TLFS_STATUS_RESET;
    next_status[`TLFS_ST_DRIVE_READY] = drive_ready_in;
    next_status[`TLFS_ST_MOTOR_OFF] = motor_off_flag_in;
    next_status[`TLFS_ST_BUS_VOLT] = sticky[`TLFS_SK_BUS_VOLT];
    next_status[`TLFS_ST_OVERCURRENT] = sticky[`TLFS_SK_OVERCURRENT];
    next_status[`TLFS_ST_OVERTEMP] = sticky[`TLFS_SK_OVERTEMP];
    next_status[`TLFS_ST_POS_ERROR] = sticky[`TLFS_SK_POS_ERROR];
    next_status[`TLFS_ST_RT_TEMP_LIMIT] = rt_temp_limit_in;
    next_status[`TLFS_ST_DERR_LIMIT] = derr_limit_in;
    next_status[`TLFS_ST_POS_EN] = pos_en;
    next_status[`TLFS_ST_NEG_EN] = neg_en;
    next_status[`TLFS_ST_POS_HIST] = sticky[`TLFS_SK_POS_HIST];
    next_status[`TLFS_ST_NEG_HIST] = sticky[`TLFS_SK_NEG_HIST];
    next_status[`TLFS_ST_POS_ASSERT] = pos_assert;
    next_status[`TLFS_ST_NEG_ASSERT] = neg_assert;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status <= `TLFS_STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  assign status_word_out = status;
  assign pos_limit_asserted_flag_out = status[`TLFS_ST_POS_ASSERT];
  assign neg_limit_asserted_flag_out = status[`TLFS_ST_NEG_ASSERT];

endmodule // tlfs_top
`default_nettype wire

// [tb/tlfs_limit_model.sv]
/*
  limit switch wiring on the local io pins.
  assumes io 2 is the positive and io 3 the negative limit.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tlfs_params.svh"

module tlfs_limit_model (
  input wire logic pos_hit_in,
  input wire logic neg_hit_in,
  output logic [`TLFS_IO_COUNT-1:0] pin_out
);
  // unwired pins float high; only io 2 and 3 feed the limits
  assign pin_out = {3'h7, neg_hit_in, pos_hit_in, 2'h3};
endmodule // tlfs_limit_model

`default_nettype wire

// [tb/tlfs_top_properties.sv]
/*
  timing checks on the status word and bus of tlfs_top.
  assumes it is bound to tlfs_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tlfs_params.svh"

module tlfs_top_checker (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [`TLFS_ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out,
  input wire logic bus_voltage_fault_in,
  input wire logic overcurrent_in,
  input wire logic overtemperature_flag_in,
  input wire logic position_error_flag_in,
  input wire logic rt_temp_limit_in,
  input wire logic derr_limit_in,
  input wire logic [`TLFS_IO_COUNT-1:0] general_use_mask_out,
  input wire logic pos_limit_asserted_flag_out,
  input wire logic neg_limit_asserted_flag_out,
  input wire tlfs_pkg::tlfs_status_t status_word_out
);
  import tlfs_pkg::*;
  logic clr_wr;
  logic [3:0] flt;
  tlfs_status_t st;
  assign st = status_word_out;
  assign flt = {position_error_flag_in, overtemperature_flag_in, overcurrent_in,
    bus_voltage_fault_in};
  assign clr_wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & (wb_adr_in == 8'h04)
    & wb_sel_in[0] & (wb_dat_in[1:0] == 2'h3);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  ack_pulse_a:
    assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  ack_latency_a:
    assert property ($rose(wb_cyc_in & wb_stb_in) |=> wb_ack_out) else $error("ack late");
  pos_asserted_a:
    assert property (general_use_mask_out[2]
      |=> !st[10] && !st[14] && !pos_limit_asserted_flag_out)
    else $error("pos limit active after release");
  neg_asserted_a:
    assert property (general_use_mask_out[3]
      |=> !st[11] && !st[15] && !neg_limit_asserted_flag_out)
    else $error("neg limit active after release");
  asserted_enabled_a:
    assert property ((st[15:14] & ~st[11:10]) == 2'h0) else $error("asserted while off");
  live_bits_a:
    assert property ($past(resetn_in) |-> st[9:8] == $past({derr_limit_in, rt_temp_limit_in}))
    else $error("live bits wrong");
  fault_latch_a:
    assert property (flt != 4'h0 |-> ##2 (st[6:3] & $past(flt, 2)) == $past(flt, 2))
    else $error("fault not latched");
  pos_hist_a:
    assert property (st[14] |=> st[12]) else $error("pos history not set");
  neg_hist_a:
    assert property (st[15] |=> st[13]) else $error("neg history not set");
  hist_clear_a:
    assert property ($fell(st[12]) || $fell(st[13]) |-> $past(clr_wr, 2))
    else $error("history dropped without clear");
endmodule // tlfs_top_checker

bind tlfs_top tlfs_top_checker u_tlfs_top_checker (.*);

`default_nettype wire

// [tb/tlfs_top_test.sv]
/*
  self-checking bench for tlfs_top over classic wishbone.
  assumes the limit model on the io pins and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none

module tlfs_top_test;
  logic ref_clk_in;
  logic resetn_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0000_0000;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  logic [6:0] pins;
  logic [6:0] mask;
  logic [3:0] flt = 4'h0;
  logic [1:0] live = 2'h0;
  logic pos_hit = 1'b1;
  logic pf;
  logic nf;
  logic [15:0] st;
  int n_fail = 0;
  int compares = 0;

  tlfs_limit_model u_tlfs_limit_model (.pos_hit_in(pos_hit), .neg_hit_in(1'b1),
    .pin_out(pins));
  tlfs_top u_tlfs_top (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .io_pin_in(pins),
    .drive_ready_in(1'b0), .motor_off_flag_in(1'b0), .bus_voltage_fault_in(flt[0]),
    .overcurrent_in(flt[1]), .overtemperature_flag_in(flt[2]),
    .position_error_flag_in(flt[3]), .rt_temp_limit_in(live[0]),
    .derr_limit_in(live[1]), .general_use_mask_out(mask),
    .pos_limit_asserted_flag_out(pf), .neg_limit_asserted_flag_out(nf),
    .status_word_out(st));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_sel_in <= 4'hf;
    wb_dat_in <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 16);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_sel_in <= 4'h0;
    if (n >= 16) n_fail++;
  endtask

  task automatic st_is(input logic [31:0] e);
    logic [31:0] q;
    repeat (10) @(posedge ref_clk_in);
    wb(1'b0, 8'h00, 32'h0000_0000, q);
    chk("status", q, e);
  endtask

  task automatic cmd(input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, 8'h04, d, q);
  endtask

  task automatic do_reset;
    resetn_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
  endtask

  task automatic s_boot;
    do_reset;
    st_is(32'h0000_fc00);
    chk("mask", {25'h0, mask}, 32'h0000_0073);
    chk("pos flag", {31'h0, pf}, 32'h0000_0001);
    chk("neg flag", {31'h0, nf}, 32'h0000_0001);
  endtask

  task automatic s_faults;
    logic [31:0] q;
    @(posedge ref_clk_in);
    flt <= 4'hf;
    live <= 2'h3;
    @(posedge ref_clk_in);
    flt <= 4'h0;
    st_is(32'h0000_ff78);
    live <= 2'h0;
    st_is(32'h0000_fc78);
    wb(1'b0, 8'h0c, 32'h0000_0000, q);
    chk("unmapped", q, 32'h0000_0000);
  endtask

  task automatic s_release;
    cmd(32'h0000_0021);
    st_is(32'h0000_b878);
    chk("pos flag", {31'h0, pf}, 32'h0000_0000);
    cmd(32'h0000_0031);
    st_is(32'h0000_3078);
    chk("neg flag", {31'h0, nf}, 32'h0000_0000);
    cmd(32'h0000_0003);
    st_is(32'h0000_0000);
  endtask

  task automatic s_word;
    logic [31:0] q;
    pos_hit <= 1'b0;
    do_reset;
    // synced pins start high; let the open pin settle before clearing
    repeat (8) @(posedge ref_clk_in);
    cmd(32'h0000_0003);
    st_is(32'h0000_ac00);
    pos_hit <= 1'b1;
    st_is(32'h0000_fc00);
    pos_hit <= 1'b0;
    st_is(32'h0000_bc00);
    cmd(32'h0000_0002);
    st_is(32'h0000_3000);
    chk("mask", {25'h0, mask}, 32'h0000_007f);
    cmd(32'h0000_0000);
    st_is(32'h0000_3000);
    wb(1'b0, 8'h08, 32'h0000_0000, q);
    chk("io state", q, 32'h0000_7f7b);
  endtask

  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    s_boot;
    s_faults;
    s_release;
    s_word;
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    print_verdict;
  end
endmodule // tlfs_top_test

`default_nettype wire
